// [logic/sostat_pkg.sv]
// sostat_pkg: register map, field layout and reset values of the
// safety output status block.
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
package sostat_pkg;
    localparam int          SOSTAT_ADDR_W     = 4;
    localparam int          SOSTAT_MAX_CH     = 4;
    // register byte addresses
    localparam logic [3:0]  SOSTAT_OFF_MON    = 4'h0;
    localparam logic [3:0]  SOSTAT_OFF_HLTH   = 4'h4;
    localparam logic [3:0]  SOSTAT_OFF_IRQST  = 4'h8;
    localparam logic [3:0]  SOSTAT_OFF_IRQEN  = 4'hc;
    // irq clear register shares the enable layout, write only
    localparam logic [3:0]  SOSTAT_OFF_IRQCLR = 4'h0;
    localparam logic [3:0]  SOSTAT_OFF_IRQCLR_HI = 4'h1;
    // first byte fields
    localparam int          SOSTAT_MON_CH_LSB = 0;
    localparam int          SOSTAT_MON_CONN   = 4;
    localparam int          SOSTAT_MON_TERMOK = 5;
    // second byte fields
    localparam int          SOSTAT_HL_UNITOK  = 0;
    localparam int          SOSTAT_HL_PWRERR  = 1;
    localparam int          SOSTAT_HL_CH_LSB  = 2;
    // interrupt events
    localparam int          SOSTAT_EV_W       = 4;
    localparam int          SOSTAT_EV_CHERR   = 0;
    localparam int          SOSTAT_EV_PWRERR  = 1;
    localparam int          SOSTAT_EV_CONNUP  = 2;
    localparam int          SOSTAT_EV_CONNDN  = 3;
    localparam logic [7:0]  SOSTAT_BYTE_RST   = 8'h00;
    localparam logic [31:0] SOSTAT_UNMAPPED   = 32'h0000_0000;
    localparam logic [31:0] SOSTAT_IRQCLR_ADR = 32'h0000_0010;
endpackage

// [logic/sostat_top.sv]
// sostat_top: read-only status bytes of a two- or four-channel safety
// output unit, with sticky event interrupt, over avalon-mm.
// assumes all status inputs are synchronous to clk.
// Operation
// R1: each channel has a monitor bit, 0 off, 1 on
// R2: four-channel variant also reports channels two and three
// R3: connection flag high only while safety connection is active
// R4: terminal health flag 1 only when no channel has an error
// R5: unit health flag 1 with no errors, 0 on any error
// R6: power error flag 1 when i/o supply bad or off
// R7: per-channel health bit in second byte, 0 error, 1 fine
// R8: everything reads zero after reset until valid; writes ignored; here writes at 0xc (irq enable) and 0x0 (irq clear) act even before valid
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sostat_top
#(
    parameter int NUM_CH = 2
) (
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    input  wire logic [sostat_pkg::SOSTAT_MAX_CH-1:0] out_on,
    input  wire logic [sostat_pkg::SOSTAT_MAX_CH-1:0] out_err,
    input  wire logic                                 conn_active,
    input  wire logic                                 unit_err,
    input  wire logic                                 io_pwr_bad,
    input  wire logic                                 status_valid,
    input  wire logic [sostat_pkg::SOSTAT_ADDR_W-1:0] avs_address,
    input  wire logic                                 avs_read,
    input  wire logic                                 avs_write,
    input  wire logic [31:0]                          avs_writedata,
    input  wire logic [3:0]                           avs_byteenable,
    output logic [31:0]                               avs_readdata,
    output logic                                      avs_waitrequest,
    output logic                                      irq
);
    import sostat_pkg::*;

    // register map, byte addresses:
    //   0x0 read: monitor byte; write: clears the interrupt status bits set in data
    //   0x4 read: health byte
    //   0x8 read: interrupt status; 0xc read and write: interrupt enable
    //   any other address reads zero, and writes elsewhere are dropped
    // the clear shares address 0x0 because the bus has only four address bits

    // channels that a variant has; bits of the channels it lacks always read zero
    localparam logic [SOSTAT_MAX_CH-1:0] CH_MASK = SOSTAT_MAX_CH'((1 << NUM_CH) - 1);

    typedef enum logic [1:0] {
        SOSTAT_IDLE = 2'b01,
        SOSTAT_ANS  = 2'b10
    } sostat_bus_e;

    typedef struct packed {
        sostat_bus_e            bus;
        logic [7:0]             mon;
        logic [7:0]             hlth;
        logic [SOSTAT_EV_W-1:0] ist;
        logic [SOSTAT_EV_W-1:0] ien;
        logic                   valid;
        logic                   conn_q;
        logic [31:0]            rdata;
        logic                   waitreq;
        logic                   irq;
    } sostat_s;

    sostat_s st;
    sostat_s next_st;

    logic [NUM_CH-1:0] ch_on;
    logic [NUM_CH-1:0] ch_err;

    // only the low NUM_CH pins exist in a variant; upper pins stay unread
    for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
        assign ch_on[k]  = out_on[k];
        assign ch_err[k] = out_err[k];
    end

    // one place decides whether a bus address selects a register
    function automatic logic sostat_hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    function automatic logic [31:0] sostat_read(input logic [3:0] a, input sostat_s s);
        logic [31:0] d;
        d = SOSTAT_UNMAPPED;
        if (sostat_hit(a, SOSTAT_OFF_MON)) begin
            d = {24'h000000, s.mon};
        end else if (sostat_hit(a, SOSTAT_OFF_HLTH)) begin
            d = {24'h000000, s.hlth};
        end else if (sostat_hit(a, SOSTAT_OFF_IRQST)) begin
            d = {28'h0000000, s.ist};
        end else if (sostat_hit(a, SOSTAT_OFF_IRQEN)) begin
            d = {28'h0000000, s.ien};
        end
        return d;
    endfunction

    always_comb begin
        logic [7:0]             m;
        logic [7:0]             h;
        logic [SOSTAT_EV_W-1:0] ev;
        logic [SOSTAT_EV_W-1:0] clr;
        logic [3:0]             a;
        m   = 8'h00;
        h   = 8'h00;
        ev  = '0;
        clr = '0;
        a   = avs_address;
        next_st = st;
        next_st.valid  = st.valid | status_valid;
        next_st.conn_q = conn_active;
        // build bytes; unused channel bits of the two-channel variant read 0
        m[SOSTAT_MON_CH_LSB +: NUM_CH] = ch_on;               // [R1] [R2]
        m[SOSTAT_MON_CONN]             = conn_active;         // [R3]
        m[SOSTAT_MON_TERMOK]           = ~(|ch_err);          // [R4]
        h[SOSTAT_HL_UNITOK]            = ~unit_err & ~io_pwr_bad & ~(|ch_err); // [R5]
        h[SOSTAT_HL_PWRERR]            = io_pwr_bad;          // [R6]
        h[SOSTAT_HL_CH_LSB +: NUM_CH]  = ~ch_err;             // [R7]
        // held at zero until status is valid; no bus write touches them
        if (st.valid) begin                                   // [R8]
            next_st.mon  = m;
            next_st.hlth = h;
        end
        ev[SOSTAT_EV_CHERR]  = st.valid & st.mon[SOSTAT_MON_TERMOK] & |ch_err;
        ev[SOSTAT_EV_PWRERR] = st.valid & ~st.hlth[SOSTAT_HL_PWRERR] & io_pwr_bad;
        ev[SOSTAT_EV_CONNUP] = st.valid & ~st.conn_q & conn_active;
        ev[SOSTAT_EV_CONNDN] = st.valid & st.conn_q & ~conn_active;
        next_st.waitreq = 1'b1;
        case (st.bus)
            SOSTAT_IDLE: begin
                if (avs_read | avs_write) begin
                    next_st.bus    = SOSTAT_ANS;
                    next_st.waitreq = 1'b0;
                    next_st.rdata  = avs_read ? sostat_read(a, st) : 32'h0;
                    if (avs_write && avs_byteenable[0]) begin
                        if (sostat_hit(a, SOSTAT_OFF_IRQCLR)) begin
                            clr = avs_writedata[SOSTAT_EV_W-1:0];
                        end else if (sostat_hit(a, SOSTAT_OFF_IRQEN)) begin
                            next_st.ien = avs_writedata[SOSTAT_EV_W-1:0];
                        end
                    end
                end
            end
            SOSTAT_ANS: begin
                next_st.bus = SOSTAT_IDLE;
            end
            default: begin
                next_st.bus = SOSTAT_IDLE;
            end
        endcase
        // a new event wins over a clear in the same cycle
        next_st.ist = (st.ist & ~clr) | ev;
        next_st.irq = |(next_st.ist & next_st.ien);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{bus: SOSTAT_IDLE, mon: SOSTAT_BYTE_RST, hlth: SOSTAT_BYTE_RST,
                    rdata: 32'h0, waitreq: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign irq             = st.irq;

    // bus steps used by the answer checks: a take, then one low cycle of
    // waitrequest; a second request is only taken once that cycle is over
    sequence seq_take;
        st.bus == SOSTAT_IDLE && (avs_read || avs_write);
    endsequence

    sequence seq_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    sequence seq_rd_take(logic [3:0] off);
        st.bus == SOSTAT_IDLE && avs_read && avs_address == off;
    endsequence

    sequence seq_wr_take(logic [3:0] off);
        st.bus == SOSTAT_IDLE && avs_write && avs_byteenable[0] && avs_address == off;
    endsequence

    chk_term_health: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid |=> st.mon[SOSTAT_MON_TERMOK] == ~(|$past(ch_err))) // [R4]
        else $error("terminal health flag wrong");
    chk_conn_flag: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && !conn_active |=> !st.mon[SOSTAT_MON_CONN]) // [R3]
        else $error("connection flag high while inactive");
    chk_power_err: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && io_pwr_bad |=> st.hlth[SOSTAT_HL_PWRERR] && !st.hlth[SOSTAT_HL_UNITOK]) // [R6]
        else $error("power error flag not set");
    chk_unit_ok: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && unit_err |=> !st.hlth[SOSTAT_HL_UNITOK]) // [R5]
        else $error("unit health high during error");
    chk_ch_mon: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid |=> st.mon[SOSTAT_MON_CH_LSB +: NUM_CH] == $past(ch_on)) // [R1]
        else $error("monitor bits wrong");
    chk_upper_ch: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid |=> st.mon[SOSTAT_MAX_CH-1:0] == ($past(out_on) & CH_MASK)) // [R2]
        else $error("absent channels read nonzero");
    chk_ch_health: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid |=> st.hlth[SOSTAT_HL_CH_LSB +: NUM_CH] == ~$past(ch_err)) // [R7]
        else $error("channel health bits wrong");
    chk_zero_invalid: assert property (@(posedge clk) disable iff (!rst_n)
        !st.valid |-> st.mon == 8'h00 && st.hlth == 8'h00) // [R8]
        else $error("status nonzero before valid");
    chk_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
        seq_take |=> seq_answer)
        else $error("bus answer timing wrong");

    // read answers carry the register as it stood at the take edge
    chk_rd_mon: assert property (@(posedge clk) disable iff (!rst_n)
        seq_rd_take(SOSTAT_OFF_MON) |=> avs_readdata == {24'h000000, $past(st.mon)}) // [R1]
        else $error("monitor byte read wrong");
    chk_rd_hlth: assert property (@(posedge clk) disable iff (!rst_n)
        seq_rd_take(SOSTAT_OFF_HLTH) |=> avs_readdata == {24'h000000, $past(st.hlth)}) // [R7]
        else $error("health byte read wrong");
    chk_rd_irqst: assert property (@(posedge clk) disable iff (!rst_n)
        seq_rd_take(SOSTAT_OFF_IRQST) |=> avs_readdata == {28'h0000000, $past(st.ist)})
        else $error("interrupt status read wrong");
    chk_rd_ien: assert property (@(posedge clk) disable iff (!rst_n)
        seq_rd_take(SOSTAT_OFF_IRQEN) |=> avs_readdata == {28'h0000000, $past(st.ien)})
        else $error("interrupt enable read wrong");
    chk_rd_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
        seq_rd_take(4'h2) |=> avs_readdata == SOSTAT_UNMAPPED)
        else $error("unmapped read not zero");
    chk_rd_on_write: assert property (@(posedge clk) disable iff (!rst_n)
        st.bus == SOSTAT_IDLE && avs_write && !avs_read |=> avs_readdata == 32'h0)
        else $error("write answer carries data");
    chk_rd_upper: assert property (@(posedge clk) disable iff (!rst_n)
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
        avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data moved outside an answer");
    chk_take_ans: assert property (@(posedge clk) disable iff (!rst_n)
        seq_take |=> st.bus == SOSTAT_ANS)
        else $error("request not taken");
    chk_ans_return: assert property (@(posedge clk) disable iff (!rst_n)
        st.bus == SOSTAT_ANS |=> st.bus == SOSTAT_IDLE)
        else $error("answer longer than one cycle");
    chk_ans_low: assert property (@(posedge clk) disable iff (!rst_n)
        st.bus == SOSTAT_ANS |-> !avs_waitrequest)
        else $error("answer without low waitrequest");
    chk_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        st.bus == SOSTAT_IDLE |-> avs_waitrequest)
        else $error("waitrequest low while idle");
    chk_bus_onehot: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot(st.bus))
        else $error("bus state not one-hot");

    // the enable register is the only one a write may set; a write at 0x0 only clears interrupt status bits
    chk_ien_write: assert property (@(posedge clk) disable iff (!rst_n)
        seq_wr_take(SOSTAT_OFF_IRQEN) |=> st.ien == $past(avs_writedata[SOSTAT_EV_W-1:0]))
        else $error("enable write lost");
    chk_ien_hold: assert property (@(posedge clk) disable iff (!rst_n)
        st.bus != SOSTAT_IDLE || !avs_write |=> $stable(st.ien))
        else $error("enable changed without write");

    // status flags follow their inputs one cycle late once valid
    chk_valid_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid |=> st.valid) // [R8]
        else $error("valid dropped before reset");
    chk_conn_set: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && conn_active |=> st.mon[SOSTAT_MON_CONN]) // [R3]
        else $error("connection flag low while active");
    chk_conn_q: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> st.conn_q == $past(conn_active))
        else $error("connection history wrong");
    chk_term_ok: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && !(|ch_err) |=> st.mon[SOSTAT_MON_TERMOK]) // [R4]
        else $error("terminal health low without error");
    chk_pwr_clear: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && !io_pwr_bad |=> !st.hlth[SOSTAT_HL_PWRERR]) // [R6]
        else $error("power error flag stuck");
    chk_unit_set: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && !unit_err && !io_pwr_bad && !(|ch_err) |=> st.hlth[SOSTAT_HL_UNITOK]) // [R5]
        else $error("unit health low without error");
    chk_unit_chan: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && (|ch_err) |=> !st.hlth[SOSTAT_HL_UNITOK]) // [R5]
        else $error("unit health high with channel error");
    chk_pad_zero: assert property (@(posedge clk) disable iff (!rst_n)
        st.mon[7:6] == 2'b00 && st.hlth[7:6] == 2'b00)
        else $error("unused byte bits set");

    // events latch into sticky status; a clear never hides a same-cycle event
    chk_ev_power: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && !st.hlth[SOSTAT_HL_PWRERR] && io_pwr_bad |=> st.ist[SOSTAT_EV_PWRERR])
        else $error("power event lost");
    chk_ev_connup: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && !st.conn_q && conn_active |=> st.ist[SOSTAT_EV_CONNUP])
        else $error("connect event lost");
    chk_ev_conndn: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && st.conn_q && !conn_active |=> st.ist[SOSTAT_EV_CONNDN])
        else $error("disconnect event lost");
    chk_ev_cherr: assert property (@(posedge clk) disable iff (!rst_n)
        st.valid && st.mon[SOSTAT_MON_TERMOK] && (|ch_err) |=> st.ist[SOSTAT_EV_CHERR])
        else $error("channel error event lost");
    chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        irq == |(st.ist & st.ien))
        else $error("interrupt level wrong");
    chk_ist_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        st.bus != SOSTAT_IDLE || !avs_write |=> (st.ist & $past(st.ist)) == $past(st.ist))
        else $error("status bit dropped without clear");
    chk_ist_invalid: assert property (@(posedge clk) disable iff (!rst_n)
        !st.valid |-> st.ist == '0)
        else $error("event before status valid");

    // per-channel bit checks, one copy for every channel that exists
    for (genvar k = 0; k < NUM_CH; k++) begin : g_chk
        chk_ch_on: assert property (@(posedge clk) disable iff (!rst_n)
            st.valid && out_on[k] |=> st.mon[SOSTAT_MON_CH_LSB + k]) // [R1]
            else $error("channel monitor not on");
        chk_ch_off: assert property (@(posedge clk) disable iff (!rst_n)
            st.valid && !out_on[k] |=> !st.mon[SOSTAT_MON_CH_LSB + k]) // [R1]
            else $error("channel monitor not off");
        chk_ch_bad: assert property (@(posedge clk) disable iff (!rst_n)
            st.valid && out_err[k] |=> !st.hlth[SOSTAT_HL_CH_LSB + k]) // [R7]
            else $error("channel health high during error");
        chk_ch_good: assert property (@(posedge clk) disable iff (!rst_n)
            st.valid && !out_err[k] |=> st.hlth[SOSTAT_HL_CH_LSB + k]) // [R7]
            else $error("channel health low without error");
    end

    // channels the variant lacks read as zero in both bytes
    for (genvar k = NUM_CH; k < SOSTAT_MAX_CH; k++) begin : g_absent
        chk_absent_ch: assert property (@(posedge clk) disable iff (!rst_n)
            !st.mon[SOSTAT_MON_CH_LSB + k] && !st.hlth[SOSTAT_HL_CH_LSB + k]) // [R2]
            else $error("absent channel bit set");
    end
endmodule
`default_nettype wire

// [testbench/sostat_ctl_model.sv]
// sostat_ctl_model: controller that reads the status unit over avalon-mm.
// assumes one request per go pulse, issued only while idle.
`timescale 1ns/1ps
`default_nettype none
module sostat_ctl_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [3:0]  adr,
    input  wire logic [31:0] wd,
    output logic             done,
    output logic [31:0]      rd,
    output logic [3:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {done, avs_read, avs_write, avs_address, avs_writedata, rd} <= '0;
            avs_byteenable <= 4'hf;
        end else begin
            done <= 1'b0;
            if (avs_read || avs_write) begin
                // hold everything until waitrequest is seen low
                if (!avs_waitrequest) begin
                    avs_read <= 1'b0;
                    avs_write <= 1'b0;
                    // released data lines must not keep the old value
                    avs_writedata <= ~avs_writedata;
                    rd <= avs_readdata;
                    done <= 1'b1;
                end
            end else if (go) begin
                avs_read <= !wr;
                avs_write <= wr;
                avs_address <= adr;
                avs_writedata <= wd;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// tb: four-channel status unit, random and corner status patterns.
// assumes reads track inputs one cycle late once valid.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sostat_pkg::*;
    logic clk = 0, rst_n = 0, go = 0, wr = 0, done, irq, wq, rq, wn, sv = 0, c = 0, u = 0, p = 0;
    logic valid_seen = 0;
    logic [3:0] adr = 0, av, be, on = 0, er = 0;
    logic [31:0] wd = 0, rd, rdat, wdat;
    int num_errors = 0, tests_run = 0, cyc = 0;
    initial forever #4 clk = ~clk;
    sostat_top #(.NUM_CH(4)) dut (.clk(clk), .rst_n(rst_n), .out_on(on), .out_err(er),
        .conn_active(c), .unit_err(u), .io_pwr_bad(p), .status_valid(sv),
        .avs_address(av), .avs_read(rq), .avs_write(wn), .avs_writedata(wdat),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq), .irq(irq));
    sostat_ctl_model ctl (.clk(clk), .rst_n(rst_n), .go(go), .wr(wr), .adr(adr), .wd(wd), .done(done),
        .rd(rd), .avs_address(av), .avs_read(rq), .avs_write(wn), .avs_writedata(wdat),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq));
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        go <= 1'b1; wr <= w; adr <= a; wd <= d;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (done !== 1'b1 && n < 20);
        if (done !== 1'b1) num_errors++;
    endtask
    // bytes expected from the present inputs
    function automatic logic [7:0] exp_b(input logic hi);
        return hi ? {2'b00, ~er, p, ~(u | p | (|er))} : {2'b00, ~|er, c, on};
    endfunction
    task automatic rd_both();
        repeat (2) @(posedge clk);
        xfer(0, SOSTAT_OFF_MON, 0);
        check(rd, {24'h0, valid_seen ? exp_b(0) : 8'h00});
        xfer(0, SOSTAT_OFF_HLTH, 0);
        check(rd, {24'h0, valid_seen ? exp_b(1) : 8'h00});
    endtask
    initial begin
        void'($urandom(18289));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        {on, er, c, u, p} <= 11'($urandom);
        rd_both();
        @(posedge clk) sv <= 1'b1;
        @(posedge clk) sv <= 1'b0;
        valid_seen = 1'b1;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            {on, er, c, u, p} <= (i == 0) ? 11'h780 : (i == 1) ? 11'h078 : 11'($urandom);
            rd_both();
        end
        xfer(1, SOSTAT_OFF_HLTH, 32'hff);
        rd_both();
        xfer(0, 4'h2, 0);
        check(rd, SOSTAT_UNMAPPED);
        @(posedge clk) {on, er, c, u, p} <= 11'h0;
        xfer(1, SOSTAT_OFF_IRQEN, 32'h2);
        xfer(1, SOSTAT_OFF_IRQCLR, 32'hf);
        xfer(0, SOSTAT_OFF_IRQST, 0);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        @(posedge clk) p <= 1'b1;
        xfer(0, SOSTAT_OFF_IRQST, 0);
        check(rd, 32'h2);
        check({31'h0, irq}, 32'h1);
        xfer(1, SOSTAT_OFF_IRQEN, 32'h0);
        xfer(0, SOSTAT_OFF_IRQST, 0);
        check(rd, 32'h2);
        check({31'h0, irq}, 32'h0);
        xfer(1, SOSTAT_OFF_IRQCLR, 32'h2);
        xfer(0, SOSTAT_OFF_IRQST, 0);
        check(rd, 32'h0);
        xfer(1, SOSTAT_OFF_IRQEN, 32'hd);
        @(posedge clk) c <= 1'b1;
        xfer(0, SOSTAT_OFF_IRQST, 0);
        check(rd, 32'h4);
        check({31'h0, irq}, 32'h1);
        @(posedge clk) {c, er} <= {1'b0, 4'h1};
        xfer(0, SOSTAT_OFF_IRQST, 0);
        check(rd, 32'hd);
        xfer(1, SOSTAT_OFF_IRQCLR, 32'hf);
        xfer(0, SOSTAT_OFF_IRQST, 0);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
